// ### logic/sbsp_device.sv
`timescale 1ns/1ps
module sbsp_device
    import sbsp_pkg::*;
#(
    parameter int WORD_W = DEF_WORD_W,
    parameter int ADDR_W = DEF_ADDR_W
)
(
    input  wire logic ref_clk,
    input  wire logic rst,
    sbsp_link_if.dev  link,
    output logic      rd_busy,
    output logic      wr_busy,
    output logic      req_dropped
);

    localparam int LANES = WORD_W / LANE_BITS;
    localparam int DEPTH = 1 << ADDR_W;

    if (!(WORD_W == 18 || WORD_W == 36)) begin : g_bad_width
        $error("sbsp_device: WORD_W must be 18 or 36");
    end
    if (ADDR_W < 2 || ADDR_W > 20) begin : g_bad_addr
        $error("sbsp_device: ADDR_W out of range");
    end

    logic [WORD_W-1:0] mem [0:DEPTH-1];

    logic                    prev_rd;
    logic                    prev_wr;
    logic                    rd_ok;
    logic                    wr_ok;
    logic                    start_rd;
    logic                    start_wr;
    logic                    drop_now;

    logic [RD_LAST_SLOT:1]   rd_vld;
    logic [ADDR_W-1:0]       rd_adr [1:RD_LAST_SLOT];
    logic [WR_LAST_SLOT:1]   wr_vld;
    logic [ADDR_W-1:0]       wr_adr [1:WR_LAST_SLOT];

    logic                    wr_hit;
    logic [ADDR_W-1:0]       wr_addr;
    logic [WORD_W-1:0]       wr_mask;
    logic [WORD_W-1:0]       wr_merged;
    logic                    rd_hit;
    logic [ADDR_W-1:0]       rd_addr;
    logic [WORD_W-1:0]       rd_word;

    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [ADDR_W-1:0] base,
        input int                idx
    );
        burst_addr = base + ADDR_W'(idx);
    endfunction

    function automatic logic [WORD_W-1:0] lane_mask(
        input logic [LANES-1:0] en_n
    );
        logic [WORD_W-1:0] m;
        m = '0;
        for (int i = 0; i < LANES; i++) begin
            m[i*LANE_BITS +: LANE_BITS] = {LANE_BITS{~en_n[i]}};
        end
        return m;
    endfunction

    // request decode, only at positive rises
    // a dropped request is never queued; the caller must ask again
    always_comb begin
        rd_ok    = link.k_pos && !link.read_port_select_n && !prev_rd;
        wr_ok    = link.k_pos && !link.write_port_select_n && !prev_wr;
        start_rd = rd_ok;
        // a read wins a shared rise; the blocked read next rise lets the write in
        start_wr = wr_ok && !rd_ok;
        drop_now = link.k_pos && ((!link.read_port_select_n && prev_rd)
                   || (!link.write_port_select_n && prev_wr)
                   || (wr_ok && rd_ok));
    end

    // remembers which port started on the last positive rise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_rd <= 1'b0;
            prev_wr <= 1'b0;
        end else if (link.k_pos) begin
            prev_rd <= start_rd;
            prev_wr <= start_wr;
        end
    end

    // start pulses and latched addresses age one half-cycle per edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_vld <= '0;
            wr_vld <= '0;
        end else begin
            rd_vld <= {rd_vld[RD_LAST_SLOT-1:1], start_rd};
            wr_vld <= {wr_vld[WR_LAST_SLOT-1:1], start_wr};
        end
    end

    // address latched on the starting rise; no reset needed, gated by the valid bits
    always_ff @(posedge ref_clk) begin
        rd_adr[1] <= link.addr;
        wr_adr[1] <= link.addr;
        for (int s = 2; s <= RD_LAST_SLOT; s++) begin
            rd_adr[s] <= rd_adr[s-1];
        end
        for (int s = 2; s <= WR_LAST_SLOT; s++) begin
            wr_adr[s] <= wr_adr[s-1];
        end
    end

    // starts on one port are four half-cycles apart, so one slot at most is live
    always_comb begin
        wr_hit  = 1'b0;
        wr_addr = '0;
        for (int s = WR_FIRST_SLOT; s <= WR_LAST_SLOT; s++) begin
            if (wr_vld[s]) begin
                wr_hit  = 1'b1;
                wr_addr = burst_addr(wr_adr[s], s - WR_FIRST_SLOT);
            end
        end
    end

    always_comb begin
        rd_hit  = 1'b0;
        rd_addr = '0;
        for (int s = RD_FIRST_SLOT; s <= RD_LAST_SLOT; s++) begin
            if (rd_vld[s]) begin
                rd_hit  = 1'b1;
                rd_addr = burst_addr(rd_adr[s], s - RD_FIRST_SLOT);
            end
        end
    end

    // per-word lane merge; an all-high mask leaves the word as stored
    always_comb begin
        wr_mask   = lane_mask(link.byte_lane_enable_n);
        wr_merged = (mem[wr_addr] & ~wr_mask) | (link.d & wr_mask);
    end

    // a write landing on the same edge is passed straight to the read;
    // earlier words of that burst are already in the array, so the
    // newest data wins without a separate forwarding register
    always_comb begin
        if (wr_hit && wr_addr == rd_addr) begin
            rd_word = wr_merged;
        end else begin
            rd_word = mem[rd_addr];
        end
    end

    // each word goes into the array as it arrives, so later reads see it
    always_ff @(posedge ref_clk) begin
        if (wr_hit) begin
            mem[wr_addr] <= wr_merged;
        end
    end

    // output launches on any edge; driver released when no word is due
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            link.q    <= '0;
            link.q_oe <= 1'b0;
        end else if (rd_hit) begin
            link.q    <= rd_word;
            link.q_oe <= 1'b1;
        end else begin
            link.q    <= '0;
            link.q_oe <= 1'b0;
        end
    end

    // status for the user side; state simply holds if ref_clk stops
    // req_dropped is a one-cycle pulse, so a watcher must look every cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_busy     <= 1'b0;
            wr_busy     <= 1'b0;
            req_dropped <= 1'b0;
        end else begin
            rd_busy     <= start_rd || (|rd_vld[RD_LAST_SLOT-1:1]);
            wr_busy     <= start_wr || (|wr_vld[WR_LAST_SLOT-1:1]);
            req_dropped <= drop_now;
        end
    end

endmodule

// ### logic/sbsp_pkg.sv
package sbsp_pkg;

    // one ref_clk cycle stands for one half-cycle of the link:
    // k_pos high marks a positive-clock rise, low a negative-clock rise
    localparam int DEF_WORD_W    = 18;
    localparam int DEF_ADDR_W    = 10;
    localparam int BURST_LEN     = 4;
    localparam int LANE_BITS     = 9;

    // device slots counted in half-cycles after the starting positive rise
    localparam int WR_FIRST_SLOT = 2;
    localparam int WR_LAST_SLOT  = WR_FIRST_SLOT + BURST_LEN - 1;
    localparam int RD_FIRST_SLOT = 5;
    localparam int RD_LAST_SLOT  = RD_FIRST_SLOT + BURST_LEN - 1;

    // controller sequence counts; one edge earlier to launch, one later to capture
    localparam int SEQ_W         = 4;
    localparam logic [SEQ_W-1:0] CTL_SEQ_IDLE = 4'h0;
    localparam logic [SEQ_W-1:0] CTL_SEQ_START = 4'h1;
    localparam logic [SEQ_W-1:0] CTL_WR_FIRST = SEQ_W'(WR_FIRST_SLOT);
    localparam logic [SEQ_W-1:0] CTL_WR_LAST  = SEQ_W'(WR_LAST_SLOT);
    localparam logic [SEQ_W-1:0] CTL_RD_FIRST = SEQ_W'(RD_FIRST_SLOT + 2);
    localparam logic [SEQ_W-1:0] CTL_RD_LAST  = SEQ_W'(RD_LAST_SLOT + 2);

endpackage

// ### logic/sbsp_link_if.sv
`timescale 1ns/1ps
interface sbsp_link_if
    import sbsp_pkg::*;
#(
    parameter int WORD_W = 18,
    parameter int ADDR_W = 10
);
    localparam int LANES = WORD_W / LANE_BITS;

    logic              k_pos;
    logic              read_port_select_n;
    logic              write_port_select_n;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] d;
    logic [LANES-1:0]  byte_lane_enable_n;
    logic [WORD_W-1:0] q;
    logic              q_oe;

    modport dev (
        input  k_pos,
        input  read_port_select_n,
        input  write_port_select_n,
        input  addr,
        input  d,
        input  byte_lane_enable_n,
        output q,
        output q_oe
    );

    modport ctl (
        output k_pos,
        output read_port_select_n,
        output write_port_select_n,
        output addr,
        output d,
        output byte_lane_enable_n,
        input  q,
        input  q_oe
    );
endinterface

// ### logic/sbsp_controller.sv
`timescale 1ns/1ps
module sbsp_controller
    import sbsp_pkg::*;
#(
    parameter int WORD_W = DEF_WORD_W,
    parameter int ADDR_W = DEF_ADDR_W
)
(
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          cmd_valid,
    input  wire logic                          cmd_write,
    input  wire logic [ADDR_W-1:0]             cmd_addr,
    input  wire logic [BURST_LEN*WORD_W-1:0]   cmd_wdata,
    input  wire logic [BURST_LEN*WORD_W/9-1:0] cmd_wmask_n,
    output logic                               cmd_ready,
    output logic                               rd_valid,
    output logic [BURST_LEN*WORD_W-1:0]        rd_data,
    sbsp_link_if.ctl                           link
);

    localparam int LANES = WORD_W / LANE_BITS;

    if (!(WORD_W == 18 || WORD_W == 36)) begin : g_bad_width
        $error("sbsp_controller: WORD_W must be 18 or 36");
    end

    logic                          accept;
    logic [SEQ_W-1:0]              wr_cnt;
    logic [SEQ_W-1:0]              rd_cnt;
    logic [SEQ_W-1:0]              next_wr_cnt;
    logic [SEQ_W-1:0]              next_rd_cnt;
    logic [BURST_LEN*WORD_W-1:0]   wbuf;
    logic [BURST_LEN*LANES-1:0]    mbuf;
    logic [BURST_LEN*WORD_W-1:0]   rbuf;
    int                            wr_idx;
    int                            rd_idx;

    function automatic logic [SEQ_W-1:0] seq_step(
        input logic [SEQ_W-1:0] cnt,
        input logic [SEQ_W-1:0] last
    );
        if (cnt == CTL_SEQ_IDLE || cnt == last) begin
            return CTL_SEQ_IDLE;
        end
        return cnt + CTL_SEQ_START;
    endfunction

    // ready only when both ports are free, so no port restarts too soon
    always_comb begin
        accept      = cmd_valid && cmd_ready;
        next_wr_cnt = (accept && cmd_write) ? CTL_SEQ_START : seq_step(wr_cnt, CTL_WR_LAST);
        next_rd_cnt = (accept && !cmd_write) ? CTL_SEQ_START : seq_step(rd_cnt, CTL_RD_LAST);
        wr_idx      = int'(wr_cnt) - int'(CTL_WR_FIRST);
        rd_idx      = int'(rd_cnt) - int'(CTL_RD_FIRST);
    end

    // k_pos alternates; ready is offered only in the cycle before a positive rise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            link.k_pos <= 1'b0;
            cmd_ready  <= 1'b0;
            wr_cnt     <= CTL_SEQ_IDLE;
            rd_cnt     <= CTL_SEQ_IDLE;
        end else begin
            link.k_pos <= !link.k_pos;
            cmd_ready  <= link.k_pos && next_wr_cnt == CTL_SEQ_IDLE
                          && next_rd_cnt == CTL_SEQ_IDLE;
            wr_cnt     <= next_wr_cnt;
            rd_cnt     <= next_rd_cnt;
        end
    end

    // selects low for exactly one positive rise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            link.read_port_select_n  <= 1'b1;
            link.write_port_select_n <= 1'b1;
            link.addr                <= '0;
        end else begin
            link.read_port_select_n  <= !(accept && !cmd_write);
            link.write_port_select_n <= !(accept && cmd_write);
            if (accept) begin
                link.addr <= cmd_addr;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (accept && cmd_write) begin
            wbuf <= cmd_wdata;
            mbuf <= cmd_wmask_n;
        end
    end

    // idle lanes stay masked so a stray slot can never write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            link.d                  <= '0;
            link.byte_lane_enable_n <= '1;
        end else if (wr_cnt >= CTL_WR_FIRST && wr_cnt <= CTL_WR_LAST) begin
            link.d                  <= wbuf[wr_idx*WORD_W +: WORD_W];
            link.byte_lane_enable_n <= mbuf[wr_idx*LANES +: LANES];
        end else begin
            link.d                  <= '0;
            link.byte_lane_enable_n <= '1;
        end
    end

    // capture four words at fixed slots; whole burst handed over at once
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else begin
            rd_valid <= 1'b0;
            if (rd_cnt == CTL_RD_LAST) begin
                rd_valid <= 1'b1;
                rd_data  <= {link.q, rbuf[(BURST_LEN-1)*WORD_W-1:0]};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rd_cnt >= CTL_RD_FIRST && rd_cnt <= CTL_RD_LAST) begin
            rbuf[rd_idx*WORD_W +: WORD_W] <= link.q;
        end
    end

endmodule

// ### testbench/sbsp_checker.sv
`timescale 1ns/1ps
module sbsp_checker #(
    parameter int WORD_W = 18,
    parameter int ADDR_W = 10
)
(
    input wire logic                ref_clk,
    input wire logic                rst,
    input wire logic                k_pos,
    input wire logic                read_port_select_n,
    input wire logic                write_port_select_n,
    input wire logic [ADDR_W-1:0]   addr,
    input wire logic [WORD_W-1:0]   d,
    input wire logic [WORD_W/9-1:0] byte_lane_enable_n,
    input wire logic [WORD_W-1:0]   q,
    input wire logic                q_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    wire rd_start = k_pos && !read_port_select_n;
    wire wr_start = k_pos && !write_port_select_n;
    wire any_sel    = !read_port_select_n || !write_port_select_n;
    wire lanes_idle = (byte_lane_enable_n == '1);

    k_pos_fall_a: assert property (k_pos |=> !k_pos)
        else $error("half-cycle marker did not fall");
    k_pos_rise_a: assert property (!k_pos |=> k_pos)
        else $error("half-cycle marker did not rise");
    sel_on_pos_a: assert property (any_sel |-> k_pos)
        else $error("select low outside a positive rise");
    rd_spacing_a: assert property (rd_start |-> ##2 read_port_select_n)
        else $error("reads started on consecutive positive rises");
    wr_spacing_a: assert property (wr_start |-> ##2 write_port_select_n)
        else $error("writes started on consecutive positive rises");
    rd_window_a: assert property (rd_start |=> !q_oe [*5] ##1 q_oe [*4] ##1 !q_oe)
        else $error("read words not in the expected four slots");
    q_idle_a: assert property (!q_oe |-> q == '0)
        else $error("read data not parked while undriven");
    wr_mask_idle_a: assert property (wr_start |=> lanes_idle ##5 lanes_idle)
        else $error("lane enables active outside the four write words");

    cover property (rd_start);
    cover property (wr_start);
    cover property (wr_start ##3 (byte_lane_enable_n == '1));
endmodule

// ### testbench/test_separate_io_burst4_sram_port.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module test_separate_io_burst4_sram_port
    import sbsp_pkg::*;
;
    localparam int W = DEF_WORD_W;
    localparam int A = DEF_ADDR_W;
    localparam int L = W / LANE_BITS;
    logic                   ref_clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   clk_stop = 1'b0;
    logic                   cmd_valid = 1'b0;
    logic                   cmd_write = 1'b0;
    logic [A-1:0]           cmd_addr = '0;
    logic [BURST_LEN*W-1:0] cmd_wdata = '0;
    logic [BURST_LEN*L-1:0] cmd_wmask_n = '1;
    logic                   cmd_ready;
    logic                   rd_valid;
    logic                   drop_b;
    logic                   busy_rd_b;
    logic                   busy_wr_b;
    logic [BURST_LEN*W-1:0] rd_data;
    logic [BURST_LEN*W-1:0] exp_v;
    logic [W-1:0]           mem [2**A];
    logic [BURST_LEN*W-1:0] exp_q [$];
    logic [A-1:0]           a;
    int                     error_cnt = 0;
    int                     n_checks = 0;
    int                     cyc = 0;
    int                     seed = 32'h11bafd01;
    int                     drops = 0;
    int                     oes = 0;
    int                     rbusy = 0;
    int                     wbusy = 0;
    int                     n;

    sbsp_link_if #(.WORD_W(W), .ADDR_W(A)) link_a ();
    // second link runs the wide word, driven by the bench to break the rules on purpose
    sbsp_link_if #(.WORD_W(36), .ADDR_W(A)) link_b ();

    initial forever begin
        #25;
        if (!clk_stop) ref_clk = ~ref_clk;
    end

    sbsp_controller #(.WORD_W(W), .ADDR_W(A)) sbsp_controller_inst (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wmask_n(cmd_wmask_n),
        .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .link(link_a));
    sbsp_device #(.WORD_W(W), .ADDR_W(A)) sbsp_device_inst (
        .ref_clk(ref_clk), .rst(rst), .link(link_a), .rd_busy(), .wr_busy(),
        .req_dropped());
    sbsp_device #(.WORD_W(36), .ADDR_W(A)) sbsp_device_inst_b (
        .ref_clk(ref_clk), .rst(rst), .link(link_b), .rd_busy(busy_rd_b), .wr_busy(busy_wr_b),
        .req_dropped(drop_b));
    sbsp_checker #(.WORD_W(W), .ADDR_W(A)) sbsp_checker_inst (
        .ref_clk(ref_clk), .rst(rst), .k_pos(link_a.k_pos),
        .read_port_select_n(link_a.read_port_select_n),
        .write_port_select_n(link_a.write_port_select_n), .addr(link_a.addr),
        .d(link_a.d), .byte_lane_enable_n(link_a.byte_lane_enable_n),
        .q(link_a.q), .q_oe(link_a.q_oe));

    task automatic finish_test();
        if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // the bench model applies each word's own lane mask, wrapping the address
    task automatic send(input logic w, input logic [A-1:0] adr, input logic [BURST_LEN*L-1:0] m);
        logic [BURST_LEN*W-1:0] wd;
        int i;
        wd = (BURST_LEN*W)'({$random(seed), $random(seed), $random(seed)});
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= adr;
        cmd_wdata <= wd;
        cmd_wmask_n <= m;
        i = 0;
        do begin
            @(posedge ref_clk);
            i++;
        end while (cmd_ready !== 1'b1 && i < 40);
        cmd_valid <= 1'b0;
        for (int j = 0; j < BURST_LEN; j++) begin
            for (int k = 0; k < L; k++) begin
                if (w && !m[j*L+k]) mem[A'(adr+j)][k*9+:9] = wd[j*W+k*9+:9];
            end
            wd[j*W+:W] = mem[A'(adr+j)];
        end
        if (!w) exp_q.push_back(wd);
    endtask

    // selects land in a cycle whose closing edge is a positive rise
    task automatic pos_sel(input logic r_n, input logic w_n, input int len);
        do @(posedge ref_clk); while (link_b.k_pos !== 1'b0);
        link_b.read_port_select_n <= r_n;
        link_b.write_port_select_n <= w_n;
        repeat (len) @(posedge ref_clk);
        link_b.read_port_select_n <= 1'b1;
        link_b.write_port_select_n <= 1'b1;
        repeat (14) @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) link_b.k_pos <= rst ? 1'b0 : ~link_b.k_pos;

    always @(posedge ref_clk) begin
        cyc++;
        if (rd_valid === 1'b1) begin
            exp_v = exp_q.size() ? exp_q.pop_front() : 'x;
            `CHK(rd_data, exp_v)
        end
        if (drop_b === 1'b1) drops++;
        if (link_b.q_oe === 1'b1) oes++;
        if (busy_rd_b === 1'b1) rbusy++;
        if (busy_wr_b === 1'b1) wbusy++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        link_b.read_port_select_n = 1'b1;
        link_b.write_port_select_n = 1'b1;
        link_b.addr = '0;
        link_b.d = '0;
        link_b.byte_lane_enable_n = '1;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        `CHK(link_a.q_oe, 1'b0)
        for (n = 0; n < 12; n++) begin
            a = (n == 0) ? A'(2**A - 2) : A'($random(seed));
            send(1'b1, a, '0);
            send(1'b1, a, (n == 1) ? '1 : (BURST_LEN*L)'($random(seed)));
            if (n == 2) begin
                // stopped clock mid-burst must lose nothing
                clk_stop = 1'b1;
                #2000;
                clk_stop = 1'b0;
            end
            send(1'b0, a, '0);
        end
        for (n = 0; n < 100 && exp_q.size() != 0; n++) @(posedge ref_clk);
        `CHK(exp_q.size(), 0)
        link_b.d <= 36'($random(seed));
        drops = 0;
        oes = 0;
        rbusy = 0;
        pos_sel(1'b0, 1'b1, 3);
        `CHK(drops, 1)
        `CHK(oes, BURST_LEN)
        `CHK(rbusy, RD_LAST_SLOT)
        drops = 0;
        oes = 0;
        rbusy = 0;
        wbusy = 0;
        // both selects held: read first, the write takes the next positive rise
        pos_sel(1'b0, 1'b0, 3);
        `CHK(drops, 2)
        `CHK(oes, BURST_LEN)
        `CHK(rbusy, RD_LAST_SLOT)
        `CHK(wbusy, WR_LAST_SLOT)
        finish_test();
    end
endmodule
